// ==== usb_status_regs.svh ====
// Register offsets, field positions, reset values and timing counts
`ifndef USB_STATUS_REGS_SVH
`define USB_STATUS_REGS_SVH
`define FRAME_COUNT_LOW_ADDR 16'hf00b
`define FRAME_COUNT_HIGH_ADDR 16'hf00c
`define WAKE_REASON_ADDR 16'hf00d
`define WAKE_LEVEL_RESET 4'h3
`define WAKE_CD_CHG_BIT 4
`define WAKE_VBUS_CHG_BIT 5
`define WAKE_PA_CHG_BIT 6
`define WAKE_PB_CHG_BIT 7
`define CLK_PERIOD_PS 5000
`define DEBOUNCE_TIME_NS 1280000
`define DEBOUNCE_CYCLES ((`DEBOUNCE_TIME_NS * 1000) / `CLK_PERIOD_PS + 1)
`endif

// ==== usb_status_pkg.sv ====
// Types shared by the frame count and wake reason logic
package usb_status_pkg;
  typedef logic [10:0] frame_number_t;
  typedef logic [2:0] microframe_number_t;
  typedef logic [18:0] debounce_count_t;
endpackage

// ==== pin_debouncer.sv ====
// One debounced input with a change pulse
`timescale 1ns/100ps
`include "usb_status_regs.svh"
module pin_debouncer #(
  parameter logic RESET_LEVEL = 1'b0,
  parameter int COUNT = `DEBOUNCE_CYCLES
) (
  // Clock and reset
  input wire logic core_clk_in,
  input wire logic rstn_in,
  // Raw and filtered pin
  input wire logic pin_in,
  output logic level_out,
  output logic change_out
);
  typedef struct packed {
    logic level;
    logic change;
    usb_status_pkg::debounce_count_t count;
  } deb_state_t;
  deb_state_t st_r;
  deb_state_t st_nxt;

  // Level accepted only after it has held longer than the window
  always_comb begin
    st_nxt = st_r;
    st_nxt.change = 1'b0;
    if (pin_in == st_r.level) begin
      st_nxt.count = '0;
    end else if (st_r.count >= usb_status_pkg::debounce_count_t'(COUNT - 1)) begin
      st_nxt.level = pin_in;
      st_nxt.change = 1'b1;
      st_nxt.count = '0;
    end else begin
      st_nxt.count = st_r.count + 19'h00001;
    end
  end

  // Register update
  always_ff @(posedge core_clk_in) begin
    if (!rstn_in) begin
      st_r <= '{level: RESET_LEVEL, change: 1'b0, count: '0};
    end else begin
      st_r <= st_nxt;
    end
  end

  assign level_out = st_r.level;
  assign change_out = st_r.change;
endmodule

// ==== usb_frame_count_wake_status.sv ====
// Frame counter capture and wake reason status registers
//
// Overview of operation
// - Load 11-bit frame number on every start-of-frame
// - Pseudo start-of-frame increments number when unlocked
// - High register: frame bits 10:8, microframe 5:3
// - Only power-up or watchdog reset clears registers
// - Change flags set only when enabled; bus-power always
// - Write one clears flag; zero leaves it
// - Wake interrupt: OR of flags and mask enable
// - Pending interrupt is not queued again
// - New source sets its flag while pending
// - Event on already set flag is ignored
// - Flags update even with interrupt disabled
// - Both card-detect pins share one change flag
// - Outside low-power suspend, transition valid only after 1.28 ms stable
// - Suspend low-power path latches changes without clock
// - Bits 3:0 show debounced pin levels
// - Set flag means event since last clear
// - Wake reason bit layout levels then changes
// - Card-detect level reads one when no card
`timescale 1ns/100ps
`include "usb_status_regs.svh"
module usb_frame_count_wake_status (
  // Clock and reset (power-up or watchdog only)
  input wire logic core_clk_in,
  input wire logic rstn_in,
  // Microcontroller external data space
  input wire logic [15:0] mcu_addr_in,
  input wire logic mcu_rd_in,
  input wire logic mcu_wr_in,
  input wire logic [7:0] mcu_wdata_in,
  output logic [7:0] mcu_rdata_out,
  // Start-of-frame stream
  input wire logic sof_valid_in,
  input wire logic [10:0] sof_frame_number_in,
  input wire logic [2:0] sof_microframe_number_in,
  input wire logic pseudo_sof_in,
  input wire logic frame_locked_in,
  // Monitored pins
  input wire logic card_detect_one_n_in,
  input wire logic card_detect_two_n_in,
  input wire logic pin_a_in,
  input wire logic pin_b_in,
  input wire logic bus_power_in,
  // Configuration from other registers
  input wire logic card_detect_one_enable_in,
  input wire logic card_detect_two_enable_in,
  input wire logic pin_a_enable_in,
  input wire logic pin_b_enable_in,
  input wire logic wake_interrupt_enable_in,
  // Suspend asynchronous path
  input wire logic suspend_in,
  input wire logic remote_wakeup_enable_in,
  input wire logic low_power_enable_in,
  input wire logic [3:0] async_change_in,
  // Interrupt
  output logic wake_interrupt_out
);
  typedef struct packed {
    usb_status_pkg::frame_number_t frame_number;
    usb_status_pkg::microframe_number_t microframe_number;
    logic [3:0] change_flags;
    logic [7:0] rdata;
    logic irq;
  } top_state_t;
  top_state_t st_r;
  top_state_t st_nxt;

  // Filter taps, one per monitored pin
  logic [4:0] raw_pins;
  logic [4:0] levels;
  logic [4:0] changes;

  // Change vectors: flag order card, bus power, pin a, pin b
  logic [3:0] deb_changes;
  logic [3:0] deb_events;
  logic [3:0] sleep_events;
  logic [3:0] events;
  logic async_path;

  // Frame stream decode
  logic sof_load;
  logic pseudo_step;

  // Register access decode
  logic wake_write;
  logic [3:0] wake_clear;
  logic rd_low;
  logic rd_high;
  logic rd_wake;
  logic [7:0] rd_byte;

  // Address match used for both reads and writes
  function automatic logic hit(
    input logic [15:0] a,
    input logic [15:0] reg_addr
  );
    hit = (a == reg_addr);
  endfunction

  // Enables on one change vector; clocked and clockless paths share it
  function automatic logic [3:0] qualify(
    input logic [3:0] chg,
    input logic card_en,
    input logic pin_a_en,
    input logic pin_b_en
  );
    qualify[0] = chg[0] && card_en;
    qualify[1] = chg[1];
    qualify[2] = chg[2] && pin_a_en;
    qualify[3] = chg[3] && pin_b_en;
  endfunction

  // Clockless capture only in suspend with remote wakeup off and low power on
  function automatic logic clockless_mode(
    input logic suspend,
    input logic remote_wakeup,
    input logic low_power
  );
    clockless_mode = suspend && !remote_wakeup && low_power;
  endfunction

  // Shared card source: either enabled card pin may set it
  function automatic logic merge_card(
    input logic chg_one,
    input logic en_one,
    input logic chg_two,
    input logic en_two
  );
    merge_card = (chg_one && en_one) ||
                 (chg_two && en_two);
  endfunction

  // Write-one-to-clear mask; a zero bit leaves its flag alone
  function automatic logic [3:0] clear_mask(
    input logic wr,
    input logic [7:0] wdata
  );
    clear_mask = 4'h0;
    if (wr) begin
      clear_mask = wdata[7:4];
    end
  endfunction

  // One local timer tick; the all-ones frame wraps to zero
  function automatic usb_status_pkg::frame_number_t step_frame(
    input usb_status_pkg::frame_number_t f
  );
    if (&f) begin
      step_frame = '0;
    end else begin
      step_frame = f + 11'h001;
    end
  endfunction

  // Sticky flags: clear applied first so a same-cycle event wins
  function automatic logic [3:0] merge_flags(
    input logic [3:0] flags,
    input logic [3:0] clr,
    input logic [3:0] ev
  );
    merge_flags = (flags & ~clr) | ev;
  endfunction

  // Level interrupt; a pending one can never stack a second
  function automatic logic wake_level(
    input logic [3:0] flags,
    input logic enable
  );
    wake_level = (|flags) && enable;
  endfunction

  // Low frame byte
  function automatic logic [7:0] low_byte(
    input usb_status_pkg::frame_number_t f
  );
    low_byte = f[7:0];
  endfunction

  // High frame byte; reserved bits 7:6 always read zero
  function automatic logic [7:0] high_byte(
    input usb_status_pkg::frame_number_t f,
    input usb_status_pkg::microframe_number_t m
  );
    high_byte = {2'b00, m, f[10:8]};
  endfunction

  // Wake reason byte: change flags above debounced levels
  function automatic logic [7:0] wake_byte(
    input logic [3:0] flags,
    input logic [3:0] lv
  );
    wake_byte = {flags, lv};
  endfunction

  // Pins in order: card one, card two, pin a, pin b, bus power
  assign raw_pins = {bus_power_in, pin_b_in, pin_a_in, card_detect_two_n_in,
                     card_detect_one_n_in};

  // One filter per monitored pin
  genvar g;
  generate
    for (g = 0; g < 5; g++) begin : g_deb
      pin_debouncer #(
        .RESET_LEVEL((g < 2) ? 1'b1 : 1'b0),
        .COUNT(`DEBOUNCE_CYCLES)
      ) u_deb (
        .core_clk_in(core_clk_in),
        .rstn_in(rstn_in),
        .pin_in(raw_pins[g]),
        .level_out(levels[g]),
        .change_out(changes[g])
      );
    end
  endgenerate

  // Frame stream: a real packet always beats the local tick
  assign sof_load = sof_valid_in;
  assign pseudo_step = pseudo_sof_in && !sof_valid_in && !frame_locked_in;

  // Register strobes; reads and writes share one address bus
  assign wake_write = mcu_wr_in && hit(mcu_addr_in, `WAKE_REASON_ADDR);
  assign wake_clear = clear_mask(wake_write, mcu_wdata_in);
  assign rd_low = mcu_rd_in && hit(mcu_addr_in, `FRAME_COUNT_LOW_ADDR);
  assign rd_high = mcu_rd_in && hit(mcu_addr_in, `FRAME_COUNT_HIGH_ADDR);
  assign rd_wake = mcu_rd_in && hit(mcu_addr_in, `WAKE_REASON_ADDR);

  // Filtered changes in flag order; card enables applied per pin
  assign deb_changes[0] = merge_card(changes[0], card_detect_one_enable_in,
                                     changes[1], card_detect_two_enable_in);
  assign deb_changes[1] = changes[4];
  assign deb_changes[2] = changes[2];
  assign deb_changes[3] = changes[3];

  // Filtered events only count after the full window
  assign deb_events = qualify(deb_changes,
                              1'b1,
                              pin_a_enable_in,
                              pin_b_enable_in);

  // Clockless path cannot tell the card pins apart, so either enable admits it
  assign sleep_events = qualify(async_change_in,
                                card_detect_one_enable_in || card_detect_two_enable_in,
                                pin_a_enable_in,
                                pin_b_enable_in);

  // Clockless path owns the flags in low-power suspend
  assign async_path = clockless_mode(suspend_in, remote_wakeup_enable_in,
                                     low_power_enable_in);

  // Event source select; filtered pulses are dropped in low-power suspend
  always_comb begin
    if (async_path) begin
      events = sleep_events;
    end else begin
      events = deb_events;
    end
  end

  // Read mux; unmapped addresses and idle cycles give zero
  always_comb begin
    rd_byte = 8'h00;
    if (rd_low) begin
      rd_byte = low_byte(st_r.frame_number);
    end else if (rd_high) begin
      rd_byte = high_byte(st_r.frame_number, st_r.microframe_number);
    end else if (rd_wake) begin
      rd_byte = wake_byte(st_r.change_flags, levels[3:0]);
    end
  end

  // Next state: frame capture, flags, interrupt, readback
  always_comb begin
    st_nxt = st_r;
    // Frame number and microframe
    if (sof_load) begin
      st_nxt.frame_number = sof_frame_number_in;
      st_nxt.microframe_number = sof_microframe_number_in;
    end else if (pseudo_step) begin
      st_nxt.frame_number = step_frame(st_r.frame_number);
    end
    // Flags see no bus reset; only rstn_in and write-one-to-clear clear them
    st_nxt.change_flags = merge_flags(st_r.change_flags,
                                      wake_clear,
                                      events);
    // Interrupt follows the new flags in the same cycle
    st_nxt.irq = wake_level(st_nxt.change_flags, wake_interrupt_enable_in);
    // Read data stands one cycle only
    st_nxt.rdata = rd_byte;
  end

  // Only the power-up or watchdog reset reaches here; bus reset does not
  always_ff @(posedge core_clk_in) begin
    if (!rstn_in) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign mcu_rdata_out = st_r.rdata;
  assign wake_interrupt_out = st_r.irq;
endmodule

// ==== usb_status_monitor.sv ====
// Port assertions for the frame count and wake reason block
`timescale 1ns/100ps
`include "usb_status_regs.svh"
module usb_status_monitor (
  // Clock, reset and register access
  input wire logic core_clk_in,
  input wire logic rstn_in,
  input wire logic [15:0] mcu_addr_in,
  input wire logic mcu_rd_in,
  input wire logic mcu_wr_in,
  input wire logic [7:0] mcu_rdata_out,
  // Frame stream, suspend path and interrupt
  input wire logic sof_valid_in,
  input wire logic [10:0] sof_frame_number_in,
  input wire logic [2:0] sof_microframe_number_in,
  input wire logic pseudo_sof_in,
  input wire logic suspend_in,
  input wire logic remote_wakeup_enable_in,
  input wire logic low_power_enable_in,
  input wire logic [3:0] async_change_in,
  input wire logic wake_interrupt_enable_in,
  input wire logic wake_interrupt_out
);
  // No frame event, so a read shows the last packet unchanged
  wire logic quiet = !sof_valid_in && !pseudo_sof_in;
  wire logic [7:0] sof_lo = sof_frame_number_in[7:0];
  wire logic [7:0] sof_hi = {2'b00, sof_microframe_number_in, sof_frame_number_in[10:8]};
  wire logic rd_wake = mcu_rd_in && !mcu_wr_in && mcu_addr_in == `WAKE_REASON_ADDR;
  wire logic mapped = mcu_addr_in == `FRAME_COUNT_LOW_ADDR
    || mcu_addr_in == `FRAME_COUNT_HIGH_ADDR || rd_wake || mcu_addr_in == `WAKE_REASON_ADDR;
  wire logic sleep = suspend_in && !remote_wakeup_enable_in && low_power_enable_in;
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (!rstn_in);
  a_sof_low_byte: assert property (
    sof_valid_in ##1 quiet ##1 (quiet && mcu_rd_in && mcu_addr_in == `FRAME_COUNT_LOW_ADDR)
    |=> mcu_rdata_out == $past(sof_lo, 3)) else $error("low frame byte differs from packet");
  a_sof_high_byte: assert property (
    sof_valid_in ##1 quiet ##1 (quiet && mcu_rd_in && mcu_addr_in == `FRAME_COUNT_HIGH_ADDR)
    |=> mcu_rdata_out == $past(sof_hi, 3)) else $error("high frame byte differs from packet");
  a_idle_read_zero: assert property (
    !(mcu_rd_in && mapped) |=> mcu_rdata_out == 8'h00) else $error("read data not zero");
  a_reset_clears: assert property (disable iff (1'b0)
    !rstn_in |=> mcu_rdata_out == 8'h00 && !wake_interrupt_out) else $error("reset not clean");
  a_irq_needs_mask: assert property (
    !wake_interrupt_enable_in ##1 !wake_interrupt_enable_in |-> !wake_interrupt_out)
    else $error("interrupt while masked");
  a_irq_from_flags: assert property (
    rd_wake && wake_interrupt_enable_in ##1 (wake_interrupt_enable_in && mcu_rdata_out[7:4] != 4'h0)
    |-> wake_interrupt_out) else $error("flags set but no interrupt");
  a_irq_sticky: assert property (
    wake_interrupt_out && !mcu_wr_in && wake_interrupt_enable_in |=> wake_interrupt_out)
    else $error("interrupt dropped without clear");
  a_async_wake: assert property (
    sleep && async_change_in[1] ##1 (wake_interrupt_enable_in && !mcu_wr_in)[*4]
    |-> wake_interrupt_out) else $error("suspend change did not wake");
  a_high_reserved_zero: assert property (
    mcu_rd_in && mcu_addr_in == `FRAME_COUNT_HIGH_ADDR |=> mcu_rdata_out[7:6] == 2'b00)
    else $error("reserved frame bits not zero");
endmodule
bind usb_frame_count_wake_status usb_status_monitor usb_status_monitor_i (.core_clk_in,
  .rstn_in, .mcu_addr_in, .mcu_rd_in, .mcu_wr_in, .mcu_rdata_out, .sof_valid_in,
  .sof_frame_number_in, .sof_microframe_number_in, .pseudo_sof_in, .suspend_in,
  .remote_wakeup_enable_in, .low_power_enable_in, .async_change_in,
  .wake_interrupt_enable_in, .wake_interrupt_out);

// ==== sof_source.sv ====
// Start-of-frame stream source standing in for the host side
`timescale 1ns/100ps
module sof_source (
  // Clock
  input wire logic core_clk_in,
  // Frame stream
  output logic sof_valid_out,
  output logic [10:0] frame_out,
  output logic [2:0] micro_out,
  output logic pseudo_out
);
  initial {sof_valid_out, frame_out, micro_out, pseudo_out} = '0;
  // One packet; field inverted once released so stale data never matches
  task automatic sof(input logic [10:0] f, input logic [2:0] m);
    @(posedge core_clk_in) {sof_valid_out, frame_out, micro_out} <= {1'b1, f, m};
    @(posedge core_clk_in) {sof_valid_out, frame_out} <= {1'b0, ~f};
  endtask
  // Missed packet: local timer tick only
  task automatic tick();
    @(posedge core_clk_in) pseudo_out <= 1'b1;
    @(posedge core_clk_in) pseudo_out <= 1'b0;
  endtask
endmodule

// ==== usb_frame_count_wake_status_tb_top.sv ====
// Self-checking bench for the frame count and wake reason block
`timescale 1ns/100ps
`include "usb_status_regs.svh"
module usb_frame_count_wake_status_tb_top;
  logic clk = 1'b0, rstn = 1'b0, rd = 1'b0, wr = 1'b0, lock = 1'b0, ien = 1'b0;
  logic pa = 1'b0, susp = 1'b0, sv, ps, irq;
  logic [15:0] addr = 16'h0;
  logic [7:0] wd = 8'h0, rdat;
  logic [3:0] en = 4'h0, ach = 4'h0;
  logic [10:0] fn;
  logic [2:0] mf;
  int err_total = 0, num_checks = 0;
  always #2.5 clk = ~clk;
  sof_source sof_source_i (.core_clk_in(clk), .sof_valid_out(sv), .frame_out(fn),
    .micro_out(mf), .pseudo_out(ps));
  usb_frame_count_wake_status usb_frame_count_wake_status_i (.core_clk_in(clk),
    .rstn_in(rstn), .mcu_addr_in(addr), .mcu_rd_in(rd), .mcu_wr_in(wr), .mcu_wdata_in(wd),
    .mcu_rdata_out(rdat), .sof_valid_in(sv), .sof_frame_number_in(fn),
    .sof_microframe_number_in(mf), .pseudo_sof_in(ps), .frame_locked_in(lock),
    .card_detect_one_n_in(1'b1), .card_detect_two_n_in(1'b1), .pin_a_in(pa),
    .pin_b_in(1'b0), .bus_power_in(1'b0), .card_detect_one_enable_in(en[0]),
    .card_detect_two_enable_in(en[1]), .pin_a_enable_in(en[2]), .pin_b_enable_in(en[3]),
    .wake_interrupt_enable_in(ien), .suspend_in(susp), .remote_wakeup_enable_in(1'b0),
    .low_power_enable_in(susp), .async_change_in(ach), .wake_interrupt_out(irq));
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("Error %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  // One access; read data lands the cycle after the taking edge
  task automatic acc(input logic w, input logic [15:0] a, input logic [7:0] d);
    @(posedge clk) {wr, rd, addr, wd} <= {w, ~w, a, d};
    @(posedge clk) {wr, rd} <= 2'b00;
    #1;
  endtask
  task automatic rdc(input logic [15:0] a, input logic [7:0] e);
    acc(1'b0, a, 8'h00);
    chk(rdat, e);
  endtask
  // Suspend-path change pulse, then settle
  task automatic pulse(input logic [3:0] v);
    @(posedge clk) ach <= v;
    @(posedge clk) ach <= 4'h0;
    repeat (2) @(posedge clk);
  endtask
  task automatic results();
    $display("checks %0d errors %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    repeat (6) @(posedge clk);
    rstn <= 1'b1;
    rdc(`WAKE_REASON_ADDR, 8'h03);
    rdc(`FRAME_COUNT_LOW_ADDR, 8'h00);
    sof_source_i.sof(11'h7ff, 3'h5);
    rdc(`FRAME_COUNT_HIGH_ADDR, 8'h2f);
    sof_source_i.sof(11'h7ff, 3'h5);
    rdc(`FRAME_COUNT_LOW_ADDR, 8'hff);
    @(posedge clk) lock <= 1'b1;
    sof_source_i.tick();
    rdc(`FRAME_COUNT_LOW_ADDR, 8'hff);
    @(posedge clk) lock <= 1'b0;
    sof_source_i.tick();
    rdc(`FRAME_COUNT_HIGH_ADDR, 8'h28);
    acc(1'b1, `FRAME_COUNT_HIGH_ADDR, 8'h3f);
    rdc(`FRAME_COUNT_HIGH_ADDR, 8'h28);
    rdc(16'hf00e, 8'h00);
    // Glitch far shorter than the filter window must not show
    @(posedge clk) pa <= 1'b1;
    repeat (100) @(posedge clk);
    pa <= 1'b0;
    rdc(`WAKE_REASON_ADDR, 8'h03);
    @(posedge clk) susp <= 1'b1;
    pulse(4'h4);
    rdc(`WAKE_REASON_ADDR, 8'h03);
    pulse(4'h2);
    rdc(`WAKE_REASON_ADDR, 8'h23);
    chk({7'h0, irq}, 8'h00);
    @(posedge clk) {ien, en} <= 5'h16;
    pulse(4'h7);
    rdc(`WAKE_REASON_ADDR, 8'h73);
    chk({7'h0, irq}, 8'h01);
    acc(1'b1, `WAKE_REASON_ADDR, 8'h2f);
    rdc(`WAKE_REASON_ADDR, 8'h53);
    acc(1'b1, `WAKE_REASON_ADDR, 8'hd0);
    rdc(`WAKE_REASON_ADDR, 8'h03);
    chk({7'h0, irq}, 8'h00);
    results();
  end
endmodule
